// file: core/nsx_exec.sv
// Execution datapath: nibble swap, xor literal, xor file, direction load
module nsx_exec (
  input  wire logic                          clk_i,          // Core clock, 125 MHz
  input  wire logic                          rst_i,          // Synchronous reset, active high
  input  wire logic                          valid_i,        // Instruction issue strobe
  input  wire nsx_pkg::nsx_op_e              op_i,           // Operation select
  input  wire logic [nsx_pkg::NSX_AW-1:0]    file_i,         // File index or direction operand
  input  wire logic                          dest_i,         // Destination select
  input  wire logic [nsx_pkg::NSX_DW-1:0]    lit_i,          // Literal operand
  output logic                               ready_o,        // Able to take an instruction
  output logic                               done_o,         // Result written at the previous edge
  output logic      [nsx_pkg::NSX_DW-1:0]    acc_o,          // Accumulator
  output logic                               zero_o,         // Zero flag
  output logic      [nsx_pkg::NSX_DW-1:0]    port_a_dir_o,   // port_a_direction
  output logic      [nsx_pkg::NSX_DW-1:0]    port_c_dir_o    // port_c_direction
);
  import nsx_pkg::*;

  // ==========================================================================
  // Sequencer: file operations need a read cycle before they execute
  // ==========================================================================
  typedef enum logic [1:0] {
    NSX_ST_IDLE = 2'b01,
    NSX_ST_EXEC = 2'b10
  } nsx_state_e;

  nsx_state_e         state_q, state_d;
  nsx_op_e            op_q;
  logic [NSX_AW-1:0]  file_q;
  logic               dest_q;
  logic [NSX_DW-1:0]  acc_q;
  logic               zero_q;
  logic [NSX_DW-1:0]  dir_a_q, dir_c_q;
  logic [NSX_DW-1:0]  fdata;
  logic [NSX_DW-1:0]  result;
  logic               mem_we;
  logic               take;
  logic               done_q;

  // Swap nibbles; used in datapath and checks
  function automatic logic [NSX_DW-1:0] nib_swap(input logic [NSX_DW-1:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  // Operations not touching memory complete in the issue cycle
  function automatic logic needs_file(input nsx_op_e op);
    return (op == NSX_OP_SWAP) || (op == NSX_OP_XOR_F);
  endfunction

  assign ready_o = (state_q == NSX_ST_IDLE);
  assign take    = valid_i && ready_o;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      NSX_ST_IDLE: begin
        if (take && needs_file(op_i)) begin
          state_d = NSX_ST_EXEC;
        end
      end
      NSX_ST_EXEC: state_d = NSX_ST_IDLE;
      default:     state_d = NSX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= NSX_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latch operands of a file operation for the execute cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q   <= NSX_OP_SWAP;
      file_q <= '0;
      dest_q <= NSX_DEST_ACC;
    end else if (take) begin
      op_q   <= op_i;
      file_q <= file_i;
      dest_q <= dest_i;
    end
  end

  // ==========================================================================
  // File register memory
  // ==========================================================================
  nsx_file_mem u_mem (
    .clk_i   (clk_i),
    .raddr_i (file_i),
    .rdata_o (fdata),
    .we_i    (mem_we),
    .waddr_i (file_q),
    .wdata_i (result)
  );

  // Result of the execute cycle
  always_comb begin
    case (op_q)
      NSX_OP_SWAP:  result = nib_swap(fdata);
      NSX_OP_XOR_F: result = acc_q ^ fdata;
      default:      result = fdata;
    endcase
  end

  // Write back to f only when destination select is 1
  assign mem_we = (state_q == NSX_ST_EXEC) && (dest_q != NSX_DEST_ACC);

  // ==========================================================================
  // Accumulator and zero flag
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= NSX_ACC_RST;
    end else if (take && op_i == NSX_OP_XOR_LIT) begin
      acc_q <= acc_q ^ lit_i;
    end else if (state_q == NSX_ST_EXEC && dest_q == NSX_DEST_ACC) begin
      acc_q <= result;
    end
  end

  // Only xor touches zero; swap and direction load leave it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_q <= NSX_ZERO_RST;
    end else if (take && op_i == NSX_OP_XOR_LIT) begin
      zero_q <= ((acc_q ^ lit_i) == '0);
    end else if (state_q == NSX_ST_EXEC && op_q == NSX_OP_XOR_F) begin
      zero_q <= (result == '0);
    end
  end

  // ==========================================================================
  // Direction registers; other operand values are ignored
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_a_q <= NSX_DIR_RST;
      dir_c_q <= NSX_DIR_RST;
    end else if (take && op_i == NSX_OP_DIRLD) begin
      if (file_i == NSX_DIR_A_SEL) begin
        dir_a_q <= acc_q;
      end
      if (file_i == NSX_DIR_C_SEL) begin
        dir_c_q <= acc_q;
      end
    end
  end

  // Completion pulse, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (take && !needs_file(op_i)) || (state_q == NSX_ST_EXEC);
    end
  end

  assign done_o       = done_q;
  assign acc_o        = acc_q;
  assign zero_o       = zero_q;
  assign port_a_dir_o = dir_a_q;
  assign port_c_dir_o = dir_c_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_xorlit_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    take && op_i == NSX_OP_XOR_LIT |=> acc_q == ($past(acc_q) ^ $past(lit_i)))
    else $error("xor literal result wrong");

  a_xorlit_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    take && op_i == NSX_OP_XOR_LIT |=> zero_q == (acc_q == '0))
    else $error("xor literal zero flag wrong");

  a_swap_acc: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == NSX_ST_EXEC && op_q == NSX_OP_SWAP && !dest_q |=> acc_q == nib_swap($past(fdata)))
    else $error("swap result wrong");

  a_swap_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == NSX_ST_EXEC && op_q == NSX_OP_SWAP |=> $stable(zero_q))
    else $error("swap changed zero flag");

  a_swap_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == NSX_ST_EXEC && op_q == NSX_OP_SWAP && dest_q |-> mem_we ##1 $stable(acc_q))
    else $error("swap destination wrong");

  a_xorf_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    take && op_i == NSX_OP_XOR_F && dest_i |=> mem_we ##1
    (u_mem.mem_q[$past(file_q)] == ($past(acc_q) ^ $past(fdata))) && $stable(acc_q))
    else $error("xor file destination wrong");

  a_xorf_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == NSX_ST_EXEC && op_q == NSX_OP_XOR_F |=> zero_q == ($past(result) == '0))
    else $error("xor file zero flag wrong");

  a_dir_load: assert property (@(posedge clk_i) disable iff (rst_i)
    take && op_i == NSX_OP_DIRLD && file_i == NSX_DIR_C_SEL |=> dir_c_q == $past(acc_q) && $stable(dir_a_q))
    else $error("direction load wrong");

  c_swap:  cover property (@(posedge clk_i) take && op_i == NSX_OP_SWAP ##2 done_o);
  c_xorf:  cover property (@(posedge clk_i) take && op_i == NSX_OP_XOR_F && dest_i ##2 done_o);
  c_zero:  cover property (@(posedge clk_i) $rose(zero_q));
  c_dirld: cover property (@(posedge clk_i) take && op_i == NSX_OP_DIRLD && file_i == NSX_DIR_A_SEL);
endmodule // nsx_exec

// file: core/nsx_pkg.sv
// Package: opcodes, operand codes and reset values for the nibble swap / xor / direction datapath
package nsx_pkg;
  // ==========================================================================
  // Operation selects from the decoder
  // ==========================================================================
  typedef enum logic [1:0] {
    NSX_OP_SWAP    = 2'h0,   // nibble_swap_op
    NSX_OP_XOR_LIT = 2'h1,   // xor_literal_op
    NSX_OP_XOR_F   = 2'h2,   // xor_file_op
    NSX_OP_DIRLD   = 2'h3    // direction_load_op
  } nsx_op_e;

  // ==========================================================================
  // Widths, operand codes, reset values
  // ==========================================================================
  localparam int unsigned NSX_DW         = 8;
  localparam int unsigned NSX_AW         = 7;
  localparam logic [6:0]  NSX_DIR_A_SEL  = 7'h05;   // Port A direction
  localparam logic [6:0]  NSX_DIR_C_SEL  = 7'h07;   // Port C direction
  localparam logic [7:0]  NSX_DIR_RST    = 8'hff;   // All inputs after reset
  localparam logic [7:0]  NSX_ACC_RST    = 8'h00;
  localparam logic        NSX_ZERO_RST   = 1'b0;
  localparam logic        NSX_DEST_ACC   = 1'b0;    // Destination select value for accumulator
  localparam int unsigned NSX_DEPTH      = 128;
endpackage : nsx_pkg

// file: core/nsx_file_mem.sv
// File register memory: 128 x 8, registered read, one write port
module nsx_file_mem (
  input  wire logic                          clk_i,     // Core clock
  input  wire logic [nsx_pkg::NSX_AW-1:0]    raddr_i,   // Read index
  output logic      [nsx_pkg::NSX_DW-1:0]    rdata_o,   // Registered read data
  input  wire logic                          we_i,      // Write strobe
  input  wire logic [nsx_pkg::NSX_AW-1:0]    waddr_i,   // Write index
  input  wire logic [nsx_pkg::NSX_DW-1:0]    wdata_i    // Write data
);
  import nsx_pkg::*;

  logic [NSX_DW-1:0] mem_q [NSX_DEPTH];

  // ==========================================================================
  // Storage; contents are undefined after reset like real data memory
  // ==========================================================================
  // Plain always so a test may preload cells; always_ff would forbid other writers
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule // nsx_file_mem

// file: sim/nsx_issuer.sv
// Decoder-side model: issues one instruction and waits for its completion
module nsx_issuer (
  input  wire logic                       clk_i,    // Core clock
  input  wire logic                       ready_i,  // Datapath can take an instruction
  input  wire logic                       done_i,   // Completion pulse
  output logic                            valid_o,  // Issue strobe
  output nsx_pkg::nsx_op_e                op_o,     // Operation select
  output logic [nsx_pkg::NSX_AW-1:0]      file_o,   // File index or direction operand
  output logic                            dest_o,   // Destination select
  output logic [nsx_pkg::NSX_DW-1:0]      lit_o     // Literal operand
);
  timeunit 1ns;
  timeprecision 1ps;
  import nsx_pkg::*;

  // ==========================================================================
  // Idle values at time zero
  // ==========================================================================
  initial begin
    valid_o = 1'b0;
    op_o = NSX_OP_SWAP;
    file_o = 7'h00;
    dest_o = 1'b0;
    lit_o = 8'h00;
  end

  // Held from a falling edge through the taking edge; then valid drops and file,
  // dest and literal are inverted (op is kept) so that nothing leans on stale operands
  task automatic issue(input nsx_op_e o, input logic [6:0] f, input logic d, input logic [7:0] l,
                       output logic ok);
    int n;
    valid_o = 1'b1;
    op_o = o;
    file_o = f;
    dest_o = d;
    lit_o = l;
    for (n = 0; n < 4; n++) begin
      if (ready_i === 1'b1) break;
      @(negedge clk_i);
    end
    ok = (n < 4);
    @(negedge clk_i);
    valid_o = 1'b0;
    file_o = ~f;
    dest_o = ~d;
    lit_o = ~l;
    for (n = 0; n < 4; n++) begin
      if (done_i === 1'b1) break;
      @(negedge clk_i);
    end
    ok = ok && (n < 4);
  endtask
endmodule // nsx_issuer

// file: sim/nibble_swap_xor_dirload_exec_tb_top.sv
// Self-checking bench for the swap / xor / direction-load datapath
module nibble_swap_xor_dirload_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nsx_pkg::*;

  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       valid, dest, ready, done, zero;
  nsx_op_e    op;
  logic [6:0] file;
  logic [7:0] lit, acc, pa, pc;
  int         bad_count = 0;
  int         n_tests = 0;

  // ==========================================================================
  // Clock, partner, device
  // ==========================================================================
  always #4 clk_i = ~clk_i;

  nsx_issuer u_iss (.clk_i(clk_i), .ready_i(ready), .done_i(done), .valid_o(valid), .op_o(op),
                    .file_o(file), .dest_o(dest), .lit_o(lit));

  nsx_exec dut (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid), .op_i(op), .file_i(file), .dest_i(dest),
                .lit_i(lit), .ready_o(ready), .done_o(done), .acc_o(acc), .zero_o(zero),
                .port_a_dir_o(pa), .port_c_dir_o(pc));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // A lost handshake ends the run at once
  task automatic run(input nsx_op_e o, input logic [6:0] f, input logic d, input logic [7:0] l);
    logic ok;
    u_iss.issue(o, f, d, l, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t handshake timeout", $time);
      results();
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_xor_lit();
    run(NSX_OP_XOR_LIT, 7'h00, 1'b0, 8'h5a);
    check(acc, 8'h5a, "xor lit acc");
    check({7'h00, zero}, 8'h00, "xor lit nonzero");
    run(NSX_OP_XOR_LIT, 7'h7f, 1'b1, 8'h5a);
    check(acc, 8'h00, "xor lit to zero");
    check({7'h00, zero}, 8'h01, "xor lit zero set");
    run(NSX_OP_XOR_LIT, 7'h00, 1'b0, 8'hff);
    check({7'h00, zero}, 8'h00, "xor lit zero clear");
  endtask

  task automatic t_dir();
    run(NSX_OP_XOR_LIT, 7'h00, 1'b0, 8'h96);
    run(NSX_OP_DIRLD, 7'h05, 1'b0, 8'h00);
    check(pa, 8'h69, "dir a load");
    run(NSX_OP_DIRLD, 7'h06, 1'b0, 8'h00);
    check(pc, 8'hff, "dir c untouched");
    run(NSX_OP_XOR_LIT, 7'h00, 1'b0, 8'h69);
    run(NSX_OP_DIRLD, 7'h07, 1'b0, 8'h00);
    check(pc, 8'h00, "dir c load");
    check(pa, 8'h69, "dir a kept");
    check({7'h00, zero}, 8'h01, "dir flags");
  endtask

  // Memory is never reset, so two cells are preloaded directly
  task automatic t_swap();
    dut.u_mem.mem_q[0] = 8'h1e;
    dut.u_mem.mem_q[127] = 8'hc3;
    run(NSX_OP_SWAP, 7'h00, 1'b0, 8'h00);
    check(acc, 8'he1, "swap to acc");
    check({7'h00, zero}, 8'h01, "swap flags");
    run(NSX_OP_SWAP, 7'h7f, 1'b1, 8'h00);
    check(acc, 8'he1, "swap to file acc kept");
    run(NSX_OP_SWAP, 7'h7f, 1'b0, 8'h00);
    check(acc, 8'hc3, "swap twice");
    run(NSX_OP_DIRLD, 7'h07, 1'b0, 8'h00);
    check(pc, 8'hc3, "dir c reload");
    check({7'h00, zero}, 8'h01, "dir keeps zero");
  endtask

  task automatic t_xor_f();
    run(NSX_OP_XOR_F, 7'h00, 1'b1, 8'h00);
    check(acc, 8'hc3, "xor f to file acc kept");
    check({7'h00, zero}, 8'h00, "xor f nonzero");
    run(NSX_OP_XOR_LIT, 7'h00, 1'b0, 8'h1e);
    run(NSX_OP_XOR_F, 7'h00, 1'b0, 8'h00);
    check(acc, 8'h00, "xor f to acc");
    check({7'h00, zero}, 8'h01, "xor f zero");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    check(acc, NSX_ACC_RST, "reset acc");
    check({pa, pc} == {NSX_DIR_RST, NSX_DIR_RST} ? 8'h01 : 8'h00, 8'h01, "reset dirs");
    t_xor_lit();
    t_dir();
    t_swap();
    t_xor_f();
    results();
  end
endmodule // nibble_swap_xor_dirload_exec_tb_top
